// *** verilog/flash_pkg.sv ***
// shared constants and types for the serial flash link and both ends
// Functional notes
// [R1] half-block erase sets addressed 32KB to ones
// [R2] block erase sets addressed 64KB to ones
// [R3] two opcodes both mean chip erase
// [R4] erase needs write enable latch set first
// [R5] addressed erases carry three address bytes
// [R6] addressed erase runs only if frame is 32 bits
// [R7] chip erase/power-down run only on 8-bit frame
// [R8] busy flag high during erase, status readable
// [R9] latch cleared as erase cycle ends, with busy
// [R10] protected block erase is dropped
// [R11] chip erase only when protect bits zero
// [R12] power-down entered after entry delay
// [R13] deep power-down ignores all but release
// [R14] power-down refused while erase runs
// [R15] reset always leaves device in standby
// [R16] select high returns to standby when idle
// [R17] reset commands do not wake the device
// [R18] release-only waits first release delay
// [R19] identifier shifted out after three dummies
// [R20] identifier repeats until select rises
// [R21] release with identifier waits second delay
// [R22] identifier works awake, not during erase
// [R23] erase and power delays are cycle counts
package flash_pkg;
    localparam logic [7:0]  OP_WRITE_ENABLE   = 8'h06;
    localparam logic [7:0]  OP_READ_STATUS    = 8'h05;
    localparam logic [7:0]  OP_HALF_BLK_ERASE = 8'h52;
    localparam logic [7:0]  OP_BLOCK_ERASE    = 8'hD8;
    localparam logic [7:0]  OP_CHIP_ERASE_A   = 8'hC7;
    localparam logic [7:0]  OP_CHIP_ERASE_B   = 8'h60;
    localparam logic [7:0]  OP_DEEP_PD        = 8'hB9;
    localparam logic [7:0]  OP_RELEASE_ID     = 8'hAB;
    localparam logic [7:0]  ERASED_BYTE       = 8'hFF;
    localparam logic [23:0] HALF_BLOCK_MASK   = 24'h007FFF;
    localparam logic [23:0] BLOCK_MASK        = 24'h00FFFF;
    localparam logic [5:0]  OPCODE_BITS       = 6'h08;
    localparam logic [5:0]  ADDR_FRAME_BITS   = 6'h20;
    localparam logic [5:0]  ADDR_LAST_BIT     = 6'h1F;
    localparam logic [5:0]  CNT_TOP           = 6'h3F;
    localparam logic [5:0]  CNT_WRAP          = 6'h38;
    localparam int          PROT_W            = 4;
    localparam int          MEM_ADDR_W        = 17;
    localparam int          REF_CLK_NS        = 20;
    localparam int          SCLK_PERIOD_NS    = 320;
    localparam int          SCLK_HALF_DIV     = SCLK_PERIOD_NS / (2 * REF_CLK_NS);
    localparam int          HALF_ERASE_CYC    = 50000;
    localparam int          BLOCK_ERASE_CYC   = 80000;
    localparam int          CHIP_ERASE_CYC    = 300000;
    localparam int          DEEP_PD_CYC       = 150;
    localparam int          RELEASE_CYC       = 150;
    localparam int          RELEASE_ID_CYC    = 90;
    localparam logic [7:0]  DEVICE_ID_DEFAULT = 8'h5A; // arbitrary value

    typedef enum logic [1:0] {
        PWR_STANDBY = 2'b00,
        PWR_ENTER   = 2'b01,
        PWR_DEEP    = 2'b10,
        PWR_RELEASE = 2'b11
    } pwr_t;

    typedef enum logic [1:0] {
        H_IDLE  = 2'b00,
        H_SHIFT = 2'b01,
        H_GAP   = 2'b10
    } host_st_t;
endpackage

// *** verilog/flash_if.sv ***
// serial link between flash host and flash device
`timescale 1ns/100ps
interface flash_if;
    logic cs_n;
    logic sclk;
    logic serial_in;
    logic serial_out;

    modport dev  (input cs_n, input sclk, input serial_in, output serial_out);
    modport host (output cs_n, output sclk, output serial_in, input serial_out);
endinterface

// *** verilog/flash_device.sv ***
// serial flash device: erase commands, deep power-down, release and identifier
//
// Chosen here: the address-and-strobe preload port.
`timescale 1ns/100ps
module flash_device #(
    parameter int         ADDR_W       = flash_pkg::MEM_ADDR_W,
    parameter int         HALF_CYC     = flash_pkg::HALF_ERASE_CYC,
    parameter int         BLOCK_CYC    = flash_pkg::BLOCK_ERASE_CYC,
    parameter int         CHIP_CYC     = flash_pkg::CHIP_ERASE_CYC,
    parameter int         DP_CYC       = flash_pkg::DEEP_PD_CYC,
    parameter int         RES1_CYC     = flash_pkg::RELEASE_CYC,
    parameter int         RES2_CYC     = flash_pkg::RELEASE_ID_CYC,
    parameter logic [7:0] DEVICE_ID    = flash_pkg::DEVICE_ID_DEFAULT
) (
    // clock, reset, enable
    input  logic                          REF_CLK,
    input  logic                          RST,
    input  logic                          CE,
    // serial link
    flash_if.dev                          link,
    // protection level
    input  logic [flash_pkg::PROT_W-1:0]  PROTECT,
    // array preload
    input  logic                          LOAD_EN,
    input  logic [ADDR_W-1:0]             LOAD_ADDR,
    input  logic [7:0]                    LOAD_DATA,
    // array inspection
    input  logic [ADDR_W-1:0]             PEEK_ADDR,
    output logic [7:0]                    PEEK_DATA,
    // state
    output logic                          WRITE_IN_PROGRESS,
    output logic                          WRITE_ENABLE_LATCH,
    output logic                          DEEP_PD
);
    import flash_pkg::*;

    logic [2:0]        sync1_q;
    logic [2:0]        sync2_q;
    logic [2:0]        prev_q;
    logic [5:0]        cnt_q, cnt_d;
    logic [7:0]        shift_q, shift_d;
    logic [7:0]        opcode_q, opcode_d;
    logic [23:0]       addr_q, addr_d;
    logic              miso_q, miso_d;
    logic              wel_q, wel_d;
    logic              busy_q, busy_d;
    logic              walk_done_q, walk_done_d;
    logic [ADDR_W-1:0] ptr_q, ptr_d;
    logic [ADDR_W-1:0] end_q, end_d;
    logic [31:0]       etimer_q, etimer_d;
    logic [31:0]       ptimer_q, ptimer_d;
    pwr_t              pwr_q, pwr_d;
    logic [7:0]        peek_q;
    logic [7:0]        mem [0:(1<<ADDR_W)-1];
    logic              mem_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [7:0]        mem_wd;
    logic              cs_s, sclk_s, mosi_s;
    logic              rise, fall, cs_rise, cs_fall, awake, prot_hit;
    logic [ADDR_W:0]   prot_lim;
    logic [7:0]        status;
    logic [ADDR_W-1:0] hb_mask, blk_mask;

    assign cs_s     = sync2_q[2];
    assign sclk_s   = sync2_q[1];
    assign mosi_s   = sync2_q[0];
    assign rise     = sclk_s & ~prev_q[1];
    assign fall     = ~sclk_s & prev_q[1];
    assign cs_rise  = cs_s & ~prev_q[2];
    assign cs_fall  = ~cs_s & prev_q[2];
    assign awake    = (pwr_q == PWR_STANDBY);
    assign hb_mask  = HALF_BLOCK_MASK[ADDR_W-1:0];
    assign blk_mask = BLOCK_MASK[ADDR_W-1:0];
    assign status   = {2'b00, PROTECT, wel_q, busy_q};
    // upper part of the array protected, unprotected lower part halving per level
    assign prot_lim = {1'b1, {ADDR_W{1'b0}}} >> PROTECT;
    assign prot_hit = (PROTECT != '0) && ({1'b0, addr_q[ADDR_W-1:0]} >= prot_lim);

    assign link.serial_out = miso_q;
    assign PEEK_DATA       = peek_q;
    assign WRITE_IN_PROGRESS             = busy_q;
    assign WRITE_ENABLE_LATCH             = wel_q;
    assign DEEP_PD         = (pwr_q == PWR_DEEP);

    always_comb begin
        cnt_d       = cnt_q;
        shift_d     = shift_q;
        opcode_d    = opcode_q;
        addr_d      = addr_q;
        miso_d      = miso_q;
        wel_d       = wel_q;
        busy_d      = busy_q;
        walk_done_d = walk_done_q;
        ptr_d       = ptr_q;
        end_d       = end_q;
        etimer_d    = etimer_q;
        ptimer_d    = ptimer_q;
        pwr_d       = pwr_q;
        mem_we      = 1'b0;
        mem_wa      = LOAD_ADDR;
        mem_wd      = LOAD_DATA;
        if (cs_fall) begin
            cnt_d = '0;
        end
        if (!cs_s && rise) begin
            shift_d = {shift_q[6:0], mosi_s};
            cnt_d   = (cnt_q == CNT_TOP) ? CNT_WRAP : cnt_q + 6'h01;
            if (cnt_q == OPCODE_BITS - 6'h01) begin
                opcode_d = {shift_q[6:0], mosi_s};
            end
            if (cnt_q >= OPCODE_BITS && cnt_q <= ADDR_LAST_BIT) begin
                addr_d = {addr_q[22:0], mosi_s}; // see [R5]
            end
        end
        if (!cs_s && fall) begin
            if (opcode_q == OP_READ_STATUS && cnt_q >= OPCODE_BITS && awake) begin
                miso_d = status[~cnt_q[2:0]]; // see [R8]
            end else if (opcode_q == OP_RELEASE_ID && cnt_q >= ADDR_FRAME_BITS && !busy_q
                         && (awake || pwr_q == PWR_DEEP)) begin
                miso_d = DEVICE_ID[~cnt_q[2:0]]; // see [R19] see [R20] see [R22]
            end
        end
        // busy: erase walk and self-timer
        if (busy_q) begin
            if (!walk_done_q) begin
                mem_we = 1'b1;
                mem_wa = ptr_q;
                mem_wd = ERASED_BYTE;
                if (ptr_q == end_q) begin
                    walk_done_d = 1'b1;
                end else begin
                    ptr_d = ptr_q + 1'b1;
                end
            end
            if (etimer_q != '0) begin
                etimer_d = etimer_q - 32'd1; // see [R23]
            end else if (walk_done_q) begin
                busy_d = 1'b0; // see [R8]
                wel_d  = 1'b0; // see [R9]
            end
        end else if (LOAD_EN) begin
            mem_we = 1'b1;
        end
        // power state timers
        if (pwr_q == PWR_ENTER || pwr_q == PWR_RELEASE) begin
            if (ptimer_q != '0) begin
                ptimer_d = ptimer_q - 32'd1;
            end else begin
                pwr_d = (pwr_q == PWR_ENTER) ? PWR_DEEP : PWR_STANDBY; // see [R12] see [R18]
            end
        end
        // frame end decode; only standby decodes, deep accepts release only
        if (cs_rise) begin // see [R16] see [R13] see [R17]
            case (opcode_q)
                OP_WRITE_ENABLE: begin
                    if (cnt_q == OPCODE_BITS && awake && !busy_q) begin
                        wel_d = 1'b1; // see [R4]
                    end
                end
                OP_HALF_BLK_ERASE, OP_BLOCK_ERASE: begin
                    if (cnt_q == ADDR_FRAME_BITS && awake && !busy_q && wel_q // see [R6] see [R4]
                        && !prot_hit) begin // see [R10]
                        busy_d      = 1'b1;
                        walk_done_d = 1'b0;
                        if (opcode_q == OP_HALF_BLK_ERASE) begin
                            ptr_d    = addr_q[ADDR_W-1:0] & ~hb_mask; // see [R1]
                            end_d    = addr_q[ADDR_W-1:0] | hb_mask;
                            etimer_d = 32'(HALF_CYC);
                        end else begin
                            ptr_d    = addr_q[ADDR_W-1:0] & ~blk_mask; // see [R2]
                            end_d    = addr_q[ADDR_W-1:0] | blk_mask;
                            etimer_d = 32'(BLOCK_CYC);
                        end
                    end
                end
                OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin // see [R3]
                    if (cnt_q == OPCODE_BITS && awake && !busy_q && wel_q // see [R7]
                        && PROTECT == '0) begin // see [R11]
                        busy_d      = 1'b1;
                        walk_done_d = 1'b0;
                        ptr_d       = '0;
                        end_d       = '1;
                        etimer_d    = 32'(CHIP_CYC);
                    end
                end
                OP_DEEP_PD: begin
                    if (cnt_q == OPCODE_BITS && awake && !busy_q) begin // see [R7] see [R14]
                        pwr_d    = PWR_ENTER;
                        ptimer_d = 32'(DP_CYC);
                    end
                end
                OP_RELEASE_ID: begin
                    if (cnt_q >= OPCODE_BITS && pwr_q == PWR_DEEP) begin
                        pwr_d    = PWR_RELEASE;
                        ptimer_d = (cnt_q == OPCODE_BITS) ? 32'(RES1_CYC) // see [R18]
                                                          : 32'(RES2_CYC); // see [R21]
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            sync1_q     <= 3'h5;
            sync2_q     <= 3'h5;
            prev_q      <= 3'h5;
            cnt_q       <= '0;
            shift_q     <= '0;
            opcode_q    <= '0;
            addr_q      <= '0;
            miso_q      <= 1'b0;
            wel_q       <= 1'b0;
            busy_q      <= 1'b0;
            walk_done_q <= 1'b1;
            ptr_q       <= '0;
            end_q       <= '0;
            etimer_q    <= '0;
            ptimer_q    <= '0;
            pwr_q       <= PWR_STANDBY; // see [R15]
            peek_q      <= '0;
        end else if (CE) begin
            sync1_q     <= {link.cs_n, link.sclk, link.serial_in};
            sync2_q     <= sync1_q;
            prev_q      <= sync2_q;
            cnt_q       <= cnt_d;
            shift_q     <= shift_d;
            opcode_q    <= opcode_d;
            addr_q      <= addr_d;
            miso_q      <= miso_d;
            wel_q       <= wel_d;
            busy_q      <= busy_d;
            walk_done_q <= walk_done_d;
            ptr_q       <= ptr_d;
            end_q       <= end_d;
            etimer_q    <= etimer_d;
            ptimer_q    <= ptimer_d;
            pwr_q       <= pwr_d;
            peek_q      <= mem[PEEK_ADDR];
        end
    end

    // array storage, no reset
    always_ff @(posedge REF_CLK) begin
        if (CE && mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end
endmodule

// *** verilog/flash_host.sv ***
// serial flash host: frames one command per request and drives the link clock
`timescale 1ns/100ps
module flash_host #(
    parameter int HALF_DIV   = flash_pkg::SCLK_HALF_DIV,
    parameter int GAP_CYCLES = flash_pkg::RELEASE_CYC
) (
    // clock, reset, enable
    input  logic        REF_CLK,
    input  logic        RST,
    input  logic        CE,
    // serial link
    flash_if.host       link,
    // command request
    input  logic        CMD_VALID,
    input  logic [7:0]  CMD_OPCODE,
    input  logic [23:0] CMD_ADDR,
    input  logic [1:0]  CMD_ADDR_BYTES,
    input  logic [3:0]  CMD_READ_BYTES,
    output logic        CMD_READY,
    // read answer
    output logic [7:0]  RD_DATA,
    output logic        RD_VALID
);
    import flash_pkg::*;

    host_st_t    st_q, st_d;
    logic [31:0] div_q, div_d;
    logic [31:0] tx_q, tx_d;
    logic [7:0]  rx_q, rx_d;
    logic [7:0]  bits_q, bits_d;
    logic [7:0]  tot_q, tot_d;
    logic [7:0]  hdr_q, hdr_d;
    logic        cs_q, cs_d, sclk_q, sclk_d, mosi_q, mosi_d;
    logic [7:0]  rdat_q, rdat_d;
    logic        rval_q, rval_d;
    logic        miso1_q, miso2_q;

    assign link.cs_n      = cs_q;
    assign link.sclk      = sclk_q;
    assign link.serial_in = mosi_q;
    assign CMD_READY      = (st_q == H_IDLE);
    assign RD_DATA        = rdat_q;
    assign RD_VALID       = rval_q;

    always_comb begin
        st_d   = st_q;
        div_d  = div_q;
        tx_d   = tx_q;
        rx_d   = rx_q;
        bits_d = bits_q;
        tot_d  = tot_q;
        hdr_d  = hdr_q;
        cs_d   = cs_q;
        sclk_d = sclk_q;
        mosi_d = mosi_q;
        rdat_d = rdat_q;
        rval_d = 1'b0;
        case (st_q)
            H_IDLE: begin
                if (CMD_VALID) begin
                    // frame length fixes where select rises; see [R5] see [R6] see [R7]
                    hdr_d  = 8'(OPCODE_BITS) + 8'({CMD_ADDR_BYTES, 3'b000});
                    tot_d  = 8'(OPCODE_BITS) + 8'({CMD_ADDR_BYTES, 3'b000})
                           + 8'({CMD_READ_BYTES, 3'b000});
                    tx_d   = {CMD_OPCODE, CMD_ADDR};
                    mosi_d = CMD_OPCODE[7];
                    cs_d   = 1'b0;
                    bits_d = '0;
                    div_d  = '0;
                    st_d   = H_SHIFT;
                end
            end
            H_SHIFT: begin
                if (div_q == 32'(HALF_DIV - 1)) begin
                    div_d = '0;
                    if (!sclk_q) begin
                        sclk_d = 1'b1;
                        rx_d   = {rx_q[6:0], miso2_q};
                        bits_d = bits_q + 8'h01;
                        if (bits_q >= hdr_q && bits_q[2:0] == 3'h7) begin
                            rdat_d = {rx_q[6:0], miso2_q}; // see [R19]
                            rval_d = 1'b1;
                        end
                    end else begin
                        sclk_d = 1'b0;
                        tx_d   = {tx_q[30:0], 1'b0};
                        mosi_d = tx_q[30];
                        if (bits_q == tot_q) begin
                            cs_d = 1'b1;
                            st_d = H_GAP;
                        end
                    end
                end else begin
                    div_d = div_q + 32'd1;
                end
            end
            H_GAP: begin
                if (div_q == 32'(GAP_CYCLES)) begin // see [R18] see [R21]
                    st_d = H_IDLE;
                end else begin
                    div_d = div_q + 32'd1;
                end
            end
            default: begin
                st_d = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            st_q    <= H_IDLE;
            div_q   <= '0;
            tx_q    <= '0;
            rx_q    <= '0;
            bits_q  <= '0;
            tot_q   <= '0;
            hdr_q   <= '0;
            cs_q    <= 1'b1;
            sclk_q  <= 1'b0;
            mosi_q  <= 1'b0;
            rdat_q  <= '0;
            rval_q  <= 1'b0;
            miso1_q <= 1'b0;
            miso2_q <= 1'b0;
        end else if (CE) begin
            st_q    <= st_d;
            div_q   <= div_d;
            tx_q    <= tx_d;
            rx_q    <= rx_d;
            bits_q  <= bits_d;
            tot_q   <= tot_d;
            hdr_q   <= hdr_d;
            cs_q    <= cs_d;
            sclk_q  <= sclk_d;
            mosi_q  <= mosi_d;
            rdat_q  <= rdat_d;
            rval_q  <= rval_d;
            miso1_q <= link.serial_out;
            miso2_q <= miso1_q;
        end
    end
endmodule

// *** test/flash_link_chk.sv ***
// checker for framing and timing on the flash serial link
`timescale 1ns/100ps
module flash_link_chk (
    // clock and reset
    input logic REF_CLK,
    input logic RST,
    // serial link
    input logic cs_n,
    input logic sclk,
    input logic serial_in,
    input logic serial_out
);
    logic       sclk_q;
    logic [5:0] bits_q;
    logic [5:0] bits_d;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    // rising link clock edges in the current frame
    always_comb begin
        bits_d = bits_q;
        if (cs_n) begin
            bits_d = 6'h00;
        end else if (sclk && !sclk_q) begin
            bits_d = bits_q + 6'h01;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            bits_q <= 6'h00;
            sclk_q <= 1'b0;
        end else begin
            bits_q <= bits_d;
            sclk_q <= sclk;
        end
    end

    a_reset_idle: assert property ($fell(RST) |-> cs_n && !sclk)
        else $error("idle lost at reset");
    a_idle_clk_low: assert property (cs_n |-> !sclk)
        else $error("clock runs deselected");
    a_first_rise: assert property ($fell(cs_n) |-> !sclk [*8] ##1 sclk)
        else $error("first rise misplaced");
    a_high_phase: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
        else $error("bad high phase");
    a_din_steady: assert property (sclk && $past(sclk) |-> $stable(serial_in))
        else $error("data in unstable");
    a_cs_rise_edge: assert property ($rose(cs_n) |-> $past(sclk))
        else $error("select rose off boundary");
    a_whole_bytes: assert property ($rose(cs_n) |-> bits_q[2:0] == 3'h0)
        else $error("partial byte frame");
    a_deselect_gap: assert property ($rose(cs_n) |=> cs_n [*8])
        else $error("select gap too short");
    a_dout_on_low: assert property ($changed(serial_out) |-> !sclk)
        else $error("data out unstable");
endmodule

// *** test/testbench.sv ***
// testbench: flash host and flash device joined over the serial link
`timescale 1ns/100ps
module testbench;
    import flash_pkg::*;

    localparam logic [16:0] marks [6]       = '{17'h00000, 17'h07FFF, 17'h08000,
                                                17'h0FFFF, 17'h10000, 17'h1FFFF};
    localparam int          limit           = 120000;

    logic        ref_clk, rst, ce, cmd_valid, cmd_ready, rd_valid, load_en, write_in_progress, write_enable_latch, deep_pd;
    logic [7:0]  cmd_opcode, rd_data, load_data, peek_data;
    logic [23:0] cmd_addr;
    logic [1:0]  cmd_addr_bytes;
    logic [3:0]  cmd_read_bytes, protect;
    logic [16:0] load_addr, peek_addr;
    logic [7:0]  rx_q [$];
    int          num_errors = 0;
    int          n_compared = 0;
    int          cycles     = 0;

    flash_if link_bus ();
    flash_device #(.HALF_CYC(10), .BLOCK_CYC(10), .RES1_CYC(20),
        .RES2_CYC(20)) i_flash_device (
        .REF_CLK(ref_clk), .RST(rst), .CE(ce), .link(link_bus.dev), .PROTECT(protect),
        .LOAD_EN(load_en), .LOAD_ADDR(load_addr), .LOAD_DATA(load_data),
        .PEEK_ADDR(peek_addr), .PEEK_DATA(peek_data), .WRITE_IN_PROGRESS(write_in_progress), .WRITE_ENABLE_LATCH(write_enable_latch), .DEEP_PD(deep_pd));
    flash_host #(.GAP_CYCLES(30)) i_flash_host (
        .REF_CLK(ref_clk), .RST(rst), .CE(ce), .link(link_bus.host), .CMD_VALID(cmd_valid),
        .CMD_OPCODE(cmd_opcode), .CMD_ADDR(cmd_addr), .CMD_ADDR_BYTES(cmd_addr_bytes),
        .CMD_READ_BYTES(cmd_read_bytes), .CMD_READY(cmd_ready), .RD_DATA(rd_data),
        .RD_VALID(rd_valid));
    flash_link_chk i_flash_link_chk (.REF_CLK(ref_clk), .RST(rst), .cs_n(link_bus.cs_n),
        .sclk(link_bus.sclk), .serial_in(link_bus.serial_in), .serial_out(link_bus.serial_out));

    always #10 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == limit) begin
            num_errors = num_errors + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] b8(input logic v);
        return {7'h00, v};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // one host command, read bytes into rx_q
    task automatic send(input logic [7:0] op, input logic [23:0] a, input logic [1:0] ab,
                        input logic [3:0] rb);
        int n = 0;
        rx_q = {};
        cmd_opcode <= op;
        cmd_addr <= a;
        cmd_addr_bytes <= ab;
        cmd_read_bytes <= rb;
        cmd_valid <= 1'b1;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        @(posedge ref_clk);
        while (cmd_ready !== 1'b1 && n < 4000) begin
            if (rd_valid === 1'b1) rx_q.push_back(rd_data);
            @(posedge ref_clk);
            n++;
        end
        check("host_ready", b8(cmd_ready), 8'h01);
    endtask

    task automatic load(input logic [16:0] a, input logic [7:0] d);
        load_addr <= a;
        load_data <= d;
        load_en <= 1'b1;
        @(posedge ref_clk);
        load_en <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic peek(input logic [16:0] a);
        peek_addr <= a;
        tick(3);
    endtask

    task automatic wait_deep();
        int n = 0;
        while (deep_pd !== 1'b1 && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        check("deep_entered", b8(deep_pd), 8'h01);
    endtask

    task automatic t_refused();
        send(OP_HALF_BLK_ERASE, 24'h001234, 2'h3, 4'h0);
        check("erase_no_latch", b8(write_in_progress), 8'h00);
        send(OP_WRITE_ENABLE, 24'h000000, 2'h0, 4'h0);
        check("latch_set", b8(write_enable_latch), 8'h01);
        send(OP_HALF_BLK_ERASE, 24'h001234, 2'h2, 4'h0);
        check("erase_short", b8(write_in_progress), 8'h00);
        send(OP_BLOCK_ERASE, 24'h001234, 2'h3, 4'h1);
        check("erase_long", b8(write_in_progress), 8'h00);
        send(OP_CHIP_ERASE_A, 24'h000000, 2'h1, 4'h0);
        check("chip_long", b8(write_in_progress), 8'h00);
        send(OP_DEEP_PD, 24'h000000, 2'h1, 4'h0);
        tick(40);
        check("sleep_long", b8(deep_pd), 8'h00);
    endtask

    task automatic t_protect();
        protect <= 4'h1;
        send(OP_BLOCK_ERASE, 24'h01ABCD, 2'h3, 4'h0);
        check("prot_block", b8(write_in_progress), 8'h00);
        check("prot_latch", b8(write_enable_latch), 8'h01);
        send(OP_CHIP_ERASE_B, 24'h000000, 2'h0, 4'h0);
        check("prot_chip", b8(write_in_progress), 8'h00);
        peek(17'h10000);
        check("prot_kept", peek_data, 8'h00);
        protect <= 4'h0;
    endtask

    task automatic t_erase(input logic [7:0] op, input logic [23:0] a);
        int n = 0;
        send(OP_WRITE_ENABLE, 24'h000000, 2'h0, 4'h0);
        send(op, a, 2'h3, 4'h0);
        check("erase_busy", b8(write_in_progress), 8'h01);
        send(OP_READ_STATUS, 24'h000000, 2'h0, 4'h1);
        check("status_busy", b8(rx_q[0][0]), 8'h01);
        while (write_in_progress === 1'b1 && n < 70000) begin
            @(posedge ref_clk);
            n++;
        end
        check("erase_done", b8(write_in_progress), 8'h00);
        check("latch_clear", b8(write_enable_latch), 8'h00);
    endtask

    task automatic t_id();
        send(OP_RELEASE_ID, 24'h000000, 2'h3, 4'h2);
        check("id_first", rx_q[0], DEVICE_ID_DEFAULT);
        check("id_again", rx_q[1], DEVICE_ID_DEFAULT);
    endtask

    task automatic t_deep();
        send(OP_WRITE_ENABLE, 24'h000000, 2'h0, 4'h0);
        send(OP_DEEP_PD, 24'h000000, 2'h0, 4'h0);
        wait_deep();
        send(OP_HALF_BLK_ERASE, 24'h001234, 2'h3, 4'h0);
        check("sleep_no_erase", b8(write_in_progress), 8'h00);
        send(8'h66, 24'h000000, 2'h0, 4'h0);
        send(8'h99, 24'h000000, 2'h0, 4'h0);
        tick(30);
        check("sleep_after_reset_ops", b8(deep_pd), 8'h01);
        send(OP_RELEASE_ID, 24'h000000, 2'h0, 4'h0);
        send(OP_READ_STATUS, 24'h000000, 2'h0, 4'h1);
        check("wake_status", rx_q[0], 8'h02);
        send(OP_DEEP_PD, 24'h000000, 2'h0, 4'h0);
        wait_deep();
        send(OP_RELEASE_ID, 24'h000000, 2'h3, 4'h1);
        send(OP_READ_STATUS, 24'h000000, 2'h0, 4'h1);
        check("wake_id_status", rx_q[0], 8'h02);
    endtask

    task automatic t_chip(input logic [7:0] op);
        load(17'h00000, 8'h00);
        send(OP_WRITE_ENABLE, 24'h000000, 2'h0, 4'h0);
        send(op, 24'h000000, 2'h0, 4'h0);
        check("chip_busy", b8(write_in_progress), 8'h01);
        send(OP_DEEP_PD, 24'h000000, 2'h0, 4'h0);
        tick(40);
        check("busy_no_sleep", b8(deep_pd), 8'h00);
        send(OP_RELEASE_ID, 24'h000000, 2'h3, 4'h1);
        check("busy_id_ignored", b8(write_in_progress), 8'h01);
        peek(17'h00000);
        check("chip_first_byte", peek_data, ERASED_BYTE);
        rst <= 1'b1;
        tick(3);
        rst <= 1'b0;
        tick(2);
        check("rst_wip", b8(write_in_progress), 8'h00);
        check("rst_standby", b8(deep_pd), 8'h00);
    endtask

    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        cmd_valid = 1'b0;
        protect = 4'h0;
        load_en = 1'b0;
        peek_addr = 17'h00000;
        tick(10);
        rst <= 1'b0;
        tick(2);
        check("start_wip", b8(write_in_progress), 8'h00);
        check("start_standby", b8(deep_pd), 8'h00);
        for (int i = 0; i < 6; i++) load(marks[i], 8'h00);
        t_refused();
        t_protect();
        t_erase(OP_HALF_BLK_ERASE, 24'h001234);
        peek(17'h00000);
        check("half_low", peek_data, ERASED_BYTE);
        peek(17'h07FFF);
        check("half_top", peek_data, ERASED_BYTE);
        peek(17'h08000);
        check("half_beyond", peek_data, 8'h00);
        t_erase(OP_BLOCK_ERASE, 24'h01ABCD);
        peek(17'h10000);
        check("block_low", peek_data, ERASED_BYTE);
        peek(17'h1FFFF);
        check("block_top", peek_data, ERASED_BYTE);
        peek(17'h0FFFF);
        check("block_below", peek_data, 8'h00);
        t_id();
        t_deep();
        t_chip(OP_CHIP_ERASE_A);
        t_chip(OP_CHIP_ERASE_B);
        end_of_test();
    end
endmodule
